/* File: logic/clk_activity.sv */
// Samples a foreign clock through three flops and reports whether it has toggled recently.
// Assumes the sampled clock is slow compared with aclk.
`timescale 1ns/100ps
module clk_activity #(
  parameter int unsigned WINDOW = 40
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_in,
  output logic alive
);
  typedef struct packed
  {
    logic [2:0] sync;
    logic [15:0] idle_cnt;
    logic [1:0] fill;
    logic level;
    logic alive;
  } act_s;

  act_s st_r;
  act_s st_nxt;

  // Synchroniser, edge finder and idle counter
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.sync = {st_r.sync[1:0], clk_in};
    if (st_r.fill != 2'h3)
    begin
      // Idle level taken while the synchroniser fills, so reset makes no false edge
      st_nxt.fill = st_r.fill + 2'h1;
      st_nxt.level = st_r.sync[1];
    end
    else if (st_r.sync[2] == st_r.sync[1] && st_r.sync[2] != st_r.level)
    begin
      st_nxt.level = st_r.sync[2];
      st_nxt.idle_cnt = 16'h0000;
      st_nxt.alive = 1'b1;
    end
    else if (st_r.idle_cnt >= WINDOW[15:0])
      st_nxt.alive = 1'b0;
    else
      st_nxt.idle_cnt = st_r.idle_cnt + 16'h0001;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign alive = st_r.alive;
endmodule

/* File: logic/phy_port_selection.sv */
// PHY port selection: MII clock source, management routing, port enable, strap, soft reset timeout.
// Assumes an AXI4-Lite master on aclk and MII clocks arriving asynchronously on pins.
// Behaviour
// - Clock field bits 6-5 pick clocks: 00/11 internal, 01 external, 10 off.
// - Clock field switches only receive and transmit clocks, not management routing.
// - Route bit 4 sends management traffic internal when 0, external when 1.
// - With route set, internal management clock and data are held low.
// - With route clear, external data pin floats and external clock is low.
// - Route bit and port enable bit act independently of each other.
// - Strap bit 3 reads management data level caught at reset.
// - Captured strap steers nothing; software reads it only.
// - Enable bit 2 set enables external port, clear enables internal PHY.
// - Enable bit affects neither management routing nor clock selection.
// - Soft reset with internal clocks stopped times out, setting bit 1.
// - Writing one to self-clearing bit 0 starts a soft reset.
`timescale 1ns/100ps
`include "phy_sel_params.svh"
module phy_port_selection #(
  parameter int unsigned SOFTWARE_RESET_REQUEST_WAIT = `SOFTWARE_RESET_REQUEST_WAIT_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic int_rx_clk,
  input wire logic int_tx_clk,
  input wire logic ext_rx_clk,
  input wire logic ext_tx_clk,
  output logic mii_rx_clk,
  output logic mii_tx_clk,
  input wire phy_sel_pkg::mgmt_mac_s mac_mgmt,
  output logic mac_mdio_i,
  output phy_sel_pkg::mgmt_pins_s int_mgmt,
  input wire logic int_mdio_i,
  output phy_sel_pkg::mgmt_pins_s ext_mgmt,
  input wire logic ext_mdio_i,
  output logic external_mii_port_enable,
  output logic internal_phy_enable,
  output logic soft_reset_pulse,
  output logic irq
);
  import phy_sel_pkg::*;

  typedef struct packed
  {
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] mii_clock_source_select;
    logic management_port_route;
    logic external_mii_port_enable;
    logic external_transceiver_present_strap;
    logic strap_taken;
    logic [1:0] strap_age;
    logic soft_reset_timeout_flag;
    software_reset_request_state_e sr_state;
    logic [15:0] sr_cnt;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [2:0] strap_sync;
  } state_s;

  state_s st_r;
  state_s st_nxt;
  logic rx_alive;
  logic tx_alive;
  logic wr_go;
  logic rd_go;
  logic [31:0] hwcfg_view;

  // Activity monitors on the internal PHY clocks
  clk_activity #(.WINDOW(`CLK_ALIVE_CYCLES)) u_rx_act (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_in(int_rx_clk),
    .alive(rx_alive)
  );

  clk_activity #(.WINDOW(`CLK_ALIVE_CYCLES)) u_tx_act (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_in(int_tx_clk),
    .alive(tx_alive)
  );

  // Register image as software sees it
  always_comb
  begin
    hwcfg_view = 32'h0000_0000;
    hwcfg_view[`CLKSEL_HI:`CLKSEL_LO] = st_r.mii_clock_source_select;
    hwcfg_view[`ROUTE_BIT] = st_r.management_port_route;
    hwcfg_view[`STRAP_BIT] = st_r.external_transceiver_present_strap;
    hwcfg_view[`EXTEN_BIT] = st_r.external_mii_port_enable;
    hwcfg_view[`TIMEOUT_BIT] = st_r.soft_reset_timeout_flag;
    hwcfg_view[`SOFTWARE_RESET_REQUEST_BIT] = (st_r.sr_state != SR_IDLE);
  end

  assign wr_go = st_r.aw_held && st_r.w_held && !st_r.bvalid;
  assign rd_go = s_axi_arvalid && !st_r.rvalid;

  // Bus slave, register file, strap capture and soft reset sequencer
  always_comb
  begin
    logic to_event;
    logic [31:0] wmask;
    to_event = 1'b0;
    wmask = {{8{st_r.wstrb[3]}}, {8{st_r.wstrb[2]}}, {8{st_r.wstrb[1]}}, {8{st_r.wstrb[0]}}};
    st_nxt = st_r;
    // Strap caught after reset release, once the second and third samples agree
    st_nxt.strap_sync = {st_r.strap_sync[1:0], ext_mdio_i};
    if (st_r.strap_age != 2'h3)
      st_nxt.strap_age = st_r.strap_age + 2'h1; // Synchroniser still filling
    else if (!st_r.strap_taken && st_r.strap_sync[2] == st_r.strap_sync[1])
    begin
      st_nxt.external_transceiver_present_strap = st_r.strap_sync[2];
      st_nxt.strap_taken = 1'b1;
    end
    // Address and data may arrive in either order
    if (s_axi_awvalid && !st_r.aw_held)
    begin
      st_nxt.aw_held = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_held)
    begin
      st_nxt.w_held = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    // Soft reset sequencer
    case (st_r.sr_state)
      SR_IDLE:
        st_nxt.sr_cnt = 16'h0000;
      SR_WAIT:
      begin
        if (rx_alive && tx_alive)
        begin
          st_nxt.sr_state = SR_PULSE;
          st_nxt.sr_cnt = 16'h0000;
        end
        else if (st_r.sr_cnt >= SOFTWARE_RESET_REQUEST_WAIT[15:0] - 16'h0001)
        begin
          st_nxt.sr_state = SR_IDLE;
          st_nxt.soft_reset_timeout_flag = 1'b1;
          to_event = 1'b1;
        end
        else
          st_nxt.sr_cnt = st_r.sr_cnt + 16'h0001;
      end
      SR_PULSE:
      begin
        if (st_r.sr_cnt >= 16'(`SOFTWARE_RESET_REQUEST_PULSE_CYCLES - 1))
          st_nxt.sr_state = SR_IDLE;
        else
          st_nxt.sr_cnt = st_r.sr_cnt + 16'h0001;
      end
      default:
        st_nxt.sr_state = SR_IDLE;
    endcase
    // Write commit
    if (wr_go)
    begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = 2'h0;
      case (st_r.awaddr)
        `HWCFG_OFFSET:
        begin
          if (st_r.wstrb[0])
          begin
            st_nxt.mii_clock_source_select = st_r.wdata[`CLKSEL_HI:`CLKSEL_LO];
            st_nxt.management_port_route = st_r.wdata[`ROUTE_BIT];
            st_nxt.external_mii_port_enable = st_r.wdata[`EXTEN_BIT];
            if (st_r.wdata[`SOFTWARE_RESET_REQUEST_BIT] && st_r.sr_state == SR_IDLE)
            begin
              st_nxt.sr_state = SR_WAIT;
              st_nxt.sr_cnt = 16'h0000;
              st_nxt.soft_reset_timeout_flag = 1'b0;
            end
          end
        end
        `IRQ_STATUS_OFFSET:
          st_nxt.irq_status = st_r.irq_status & ~(st_r.wdata[1:0] & wmask[1:0]);
        `IRQ_MASK_OFFSET:
          if (st_r.wstrb[0])
            st_nxt.irq_mask = st_r.wdata[1:0];
        default:
          st_nxt.bresp = 2'h2;
      endcase
    end
    // Sticky events; a set wins over a same-cycle clear
    if (to_event)
      st_nxt.irq_status[0] = 1'b1;
    if (st_r.sr_state == SR_PULSE && st_nxt.sr_state == SR_IDLE)
      st_nxt.irq_status[1] = 1'b1;
    if (st_r.bvalid && s_axi_bready)
      st_nxt.bvalid = 1'b0;
    // Read channel
    if (rd_go)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = 2'h0;
      case (s_axi_araddr)
        `HWCFG_OFFSET:
          st_nxt.rdata = hwcfg_view;
        `IRQ_STATUS_OFFSET:
          st_nxt.rdata = {30'h0000_0000, st_r.irq_status};
        `IRQ_MASK_OFFSET:
          st_nxt.rdata = {30'h0000_0000, st_r.irq_mask};
        default:
        begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rresp = 2'h2;
        end
      endcase
    end
    else if (st_r.rvalid && s_axi_rready)
      st_nxt.rvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= '0;
      st_r.mii_clock_source_select <= `CLKSEL_RESET;
    end
    else
      st_r <= st_nxt;
  end

  // Bus handshake outputs
  assign s_axi_awready = !st_r.aw_held;
  assign s_axi_wready = !st_r.w_held;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;

  // Clock mux driven only by the clock field
  always_comb
  begin
    case (clk_src_e'(st_r.mii_clock_source_select))
      CLK_EXTERNAL:
      begin
        mii_rx_clk = ext_rx_clk;
        mii_tx_clk = ext_tx_clk;
      end
      CLK_DISABLED:
      begin
        mii_rx_clk = 1'b0;
        mii_tx_clk = 1'b0;
      end
      default:
      begin
        mii_rx_clk = int_rx_clk;
        mii_tx_clk = int_tx_clk;
      end
    endcase
  end

  // Management routing driven only by the route bit
  always_comb
  begin
    if (st_r.management_port_route)
    begin
      int_mgmt = '0;
      int_mgmt.mdio_oe = 1'b1;
      ext_mgmt = mac_mgmt;
      mac_mdio_i = ext_mdio_i;
    end
    else
    begin
      ext_mgmt = '0;
      int_mgmt = mac_mgmt;
      mac_mdio_i = int_mdio_i;
    end
  end

  // Port enables from the enable bit only
  assign external_mii_port_enable = st_r.external_mii_port_enable;
  assign internal_phy_enable = !st_r.external_mii_port_enable;
  assign soft_reset_pulse = (st_r.sr_state == SR_PULSE);
  assign irq = |(st_r.irq_status & st_r.irq_mask);

  // Checks
  chk_clk_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.mii_clock_source_select == 2'h2) |-> (!mii_rx_clk && !mii_tx_clk))
    else $error("clocks not stopped when disabled");
  chk_clk_external: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.mii_clock_source_select == 2'h1) |-> (mii_rx_clk == ext_rx_clk && mii_tx_clk == ext_tx_clk))
    else $error("external clock not selected");
  chk_route_int_low: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r.management_port_route |-> (!int_mgmt.mdc && !int_mgmt.mdio_o && ext_mgmt == mac_mgmt))
    else $error("internal management not held low");
  chk_route_ext_float: assert property (@(posedge aclk) disable iff (!aresetn)
    !st_r.management_port_route |-> (!ext_mgmt.mdio_oe && !ext_mgmt.mdc && int_mgmt == mac_mgmt))
    else $error("external management not released");
  chk_enable_split: assert property (@(posedge aclk) disable iff (!aresetn)
    external_mii_port_enable != internal_phy_enable)
    else $error("port enables overlap");
  chk_strap_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r.strap_taken |=> $stable(st_r.external_transceiver_present_strap))
    else $error("strap changed after capture");
  chk_timeout_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.sr_state == SR_WAIT && !(rx_alive && tx_alive) && st_r.sr_cnt >= SOFTWARE_RESET_REQUEST_WAIT[15:0] - 16'h0001)
    |=> (st_r.soft_reset_timeout_flag && st_r.irq_status[0]))
    else $error("timeout flag not set");
  chk_software_reset_request_start: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && st_r.awaddr == `HWCFG_OFFSET && st_r.wstrb[0] && st_r.wdata[0] && st_r.sr_state == SR_IDLE)
    |=> (st_r.sr_state == SR_WAIT) ##1 (hwcfg_view[0] == 1'b1))
    else $error("soft reset did not start");
  chk_pulse_len: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(soft_reset_pulse) |-> soft_reset_pulse[*4] ##1 !soft_reset_pulse)
    else $error("soft reset pulse length wrong");
  chk_strap_settle: assert property (@(posedge aclk) disable iff (!aresetn)
    (!st_r.strap_taken && st_r.strap_age == 2'h3 && st_r.strap_sync[2] == st_r.strap_sync[1])
    |=> (st_r.strap_taken && st_r.external_transceiver_present_strap == $past(st_r.strap_sync[2])))
    else $error("strap not captured from settled samples");
endmodule

/* File: logic/phy_sel_params.svh */
// Offsets, field positions, reset values and timing counts for the PHY port selection block.
// Assumes a 10 MHz system clock and a byte-addressed AXI4-Lite register space.
`ifndef PHY_SEL_PARAMS_SVH
`define PHY_SEL_PARAMS_SVH

`define HWCFG_OFFSET 8'h00
`define IRQ_STATUS_OFFSET 8'h04
`define IRQ_MASK_OFFSET 8'h08
`define CLKSEL_HI 6
`define CLKSEL_LO 5
`define ROUTE_BIT 4
`define STRAP_BIT 3
`define EXTEN_BIT 2
`define TIMEOUT_BIT 1
`define SOFTWARE_RESET_REQUEST_BIT 0
`define CLKSEL_RESET 2'h0
`define CLK_PERIOD_NS 100
`define SOFTWARE_RESET_REQUEST_WAIT_NS 20000
`define SOFTWARE_RESET_REQUEST_WAIT_CYCLES ((`SOFTWARE_RESET_REQUEST_WAIT_NS) / (`CLK_PERIOD_NS))
`define CLK_ALIVE_NS 4000
`define CLK_ALIVE_CYCLES ((`CLK_ALIVE_NS) / (`CLK_PERIOD_NS))
`define SOFTWARE_RESET_REQUEST_PULSE_CYCLES 4

`endif

/* File: logic/phy_sel_pkg.sv */
// Types shared by the PHY port selection block.
// Assumes the parameter header is included by the users of these types.
package phy_sel_pkg;

  typedef enum logic [1:0]
  {
    CLK_INTERNAL,
    CLK_EXTERNAL,
    CLK_DISABLED,
    CLK_INTERNAL_ALT
  } clk_src_e;

  typedef enum logic [1:0]
  {
    SR_IDLE,
    SR_WAIT,
    SR_PULSE
  } software_reset_request_state_e;

  // Management port pin group
  typedef struct packed
  {
    logic mdc;
    logic mdio_o;
    logic mdio_oe;
  } mgmt_pins_s;

  // Management port from the MAC
  typedef struct packed
  {
    logic mdc;
    logic mdio_o;
    logic mdio_oe;
  } mgmt_mac_s;

endpackage

/* File: test/phy_model.sv */
// Behavioural PHY side: internal and external MII clocks, management data lines pulled high (internal) or to pull_level (external).
// Assumes the bench starts and stops the internal clocks through int_run.
`timescale 1ns/100ps
module phy_model (
  input wire logic int_run,
  input wire logic pull_level,
  input wire phy_sel_pkg::mgmt_pins_s int_mgmt,
  input wire phy_sel_pkg::mgmt_pins_s ext_mgmt,
  output logic int_rx_clk,
  output logic int_tx_clk,
  output logic ext_rx_clk,
  output logic ext_tx_clk,
  output logic int_mdio_i,
  output logic ext_mdio_i
);
  import phy_sel_pkg::*;

  // Link clocks, 800 ns period; internal pair stands still while stopped
  initial
  begin
    int_rx_clk = 1'b0;
    ext_rx_clk = 1'b1;
    #37;
    forever
    begin
      #400;
      if (int_run)
        int_rx_clk = ~int_rx_clk;
      ext_rx_clk = ~ext_rx_clk;
    end
  end

  // Transmit clocks lag receive clocks so a swap shows
  assign #200 int_tx_clk = int_rx_clk;
  assign #200 ext_tx_clk = ext_rx_clk;

  // Released data lines float to their pull levels: internal high, external to pull_level
  assign int_mdio_i = int_mgmt.mdio_oe ? int_mgmt.mdio_o : 1'b1;
  assign ext_mdio_i = ext_mgmt.mdio_oe ? ext_mgmt.mdio_o : pull_level;
endmodule

/* File: test/phy_port_selection_tb.sv */
// Bench for PHY port selection: bus tasks, clock mux, management routing, soft reset, interrupt.
// Assumes the PHY model drives all MII clocks and, when released, holds the internal data line high and the external one at pull_level.
`timescale 1ns/100ps
module phy_port_selection_tb;
  import phy_sel_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic int_rx_clk, int_tx_clk, ext_rx_clk, ext_tx_clk, mii_rx_clk, mii_tx_clk, mac_mdio_i;
  logic int_mdio_i, ext_mdio_i, external_mii_port_enable, internal_phy_enable, soft_reset_pulse, irq, int_run;
  logic pull_level;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, cfg;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  mgmt_mac_s mac_mgmt;
  mgmt_pins_s int_mgmt, ext_mgmt;
  int n_fail, check_count, w;

  phy_port_selection #(.SOFTWARE_RESET_REQUEST_WAIT(20)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .int_rx_clk, .int_tx_clk, .ext_rx_clk, .ext_tx_clk, .mii_rx_clk, .mii_tx_clk, .mac_mgmt, .mac_mdio_i,
    .int_mgmt, .int_mdio_i, .ext_mgmt, .ext_mdio_i, .external_mii_port_enable, .internal_phy_enable,
    .soft_reset_pulse, .irq);

  phy_model phy (.int_run, .int_mgmt, .ext_mgmt, .int_rx_clk, .int_tx_clk, .ext_rx_clk, .ext_tx_clk,
    .int_mdio_i, .ext_mdio_i, .pull_level);

  // System clock, 100 ns
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic summarize;
    $display("checks=%0d errors=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One clock edge of a bounded wait
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 400)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, n, 0);
      summarize();
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      tick(n);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      tick(n);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] resp);
    axi_rd(a);
    chk(rd, exp);
    chk(rsp, resp);
  endtask

  task automatic irq_chk(input logic exp);
    repeat (2) @(negedge aclk);
    chk(irq, exp);
  endtask

  // Soft reset request that must finish with a pulse of four cycles
  task automatic pulse_chk;
    int n;
    n = 0;
    axi_wr(8'h00, 32'h1);
    while (!soft_reset_pulse)
      tick(n);
    w = 0;
    do
    begin
      w++;
      tick(n);
    end while (soft_reset_pulse);
    chk(w, 32'd4);
  endtask

  initial
  begin
    n_fail = 0;
    check_count = 0;
    aresetn = 1'b0;
    int_run = 1'b1;
    pull_level = 1'b1;
    mac_mgmt = 3'b111;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    rd_chk(8'h00, 32'h8, 2'h0);
    rd_chk(8'h0C, 32'h0, 2'h2);
    axi_wr(8'h0C, 32'h0);
    chk(rsp, 2'h2);
    // Every clock source, route and enable combination
    for (int v = 0; v < 16; v++)
    begin
      cfg = {25'h0, v[3:2], v[1], 1'b0, v[0], 2'b00};
      mac_mgmt <= {1'b1, v[1], 1'b1}; // Driven level differs from the unselected side's level
      axi_wr(8'h00, cfg);
      chk(rsp, 2'h0);
      rd_chk(8'h00, cfg | 32'h8, 2'h0);
      chk({external_mii_port_enable, internal_phy_enable}, {v[0], !v[0]});
      chk(v[1] ? ext_mgmt : int_mgmt, mac_mgmt);
      chk(v[1] ? int_mgmt : ext_mgmt, v[1] ? 3'b001 : 3'b000);
      chk(mac_mdio_i, v[1]);
      repeat (20)
      begin
        @(negedge aclk);
        chk({mii_rx_clk, mii_tx_clk}, v[3:2] == 2'b01 ? {ext_rx_clk, ext_tx_clk} :
          v[3:2] == 2'b10 ? 2'b00 : {int_rx_clk, int_tx_clk});
      end
    end
    // Soft reset with the internal clocks running
    axi_wr(8'h00, 32'h0);
    axi_wr(8'h08, 32'h3);
    pulse_chk();
    rd_chk(8'h04, 32'h2, 2'h0);
    irq_chk(1'b1);
    axi_wr(8'h04, 32'h2);
    irq_chk(1'b0);
    // Soft reset with the internal clocks stopped
    int_run = 1'b0;
    repeat (60) @(posedge aclk);
    axi_wr(8'h00, 32'h1);
    rd = '0;
    for (int i = 0; i < 60 && !rd[1]; i++)
      axi_rd(8'h00);
    chk(rd, 32'hA);
    rd_chk(8'h04, 32'h1, 2'h0);
    irq_chk(1'b1);
    axi_wr(8'h08, 32'h0);
    irq_chk(1'b0);
    axi_wr(8'h08, 32'h3);
    irq_chk(1'b1);
    axi_wr(8'h04, 32'h1);
    irq_chk(1'b0);
    rd_chk(8'h04, 32'h0, 2'h0);
    // Host restarts the clocks and asks again
    int_run = 1'b1;
    repeat (20) @(posedge aclk);
    pulse_chk();
    rd_chk(8'h00, 32'h8, 2'h0);
    // Hard reset with the management data line pulled low
    pull_level = 1'b0;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    rd_chk(8'h00, 32'h0, 2'h0);
    rd_chk(8'h04, 32'h0, 2'h0);
    chk(irq, 1'b0);
    summarize();
  end
endmodule
